// file: rtl/timer_ccr_regs.sv
// Timer channel value registers and burst access window, register side
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module timer_ccr_regs #(
    parameter bit WIDE = 1'b0
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Timer kernel
    input  wire logic [31:0] counter,
    input  wire logic [3:0]  capture_event,
    input  wire logic [3:0]  capture_level,
    output logic      [3:0]  compare_match,
    // Burst status
    output logic      [4:0]  burst_index,
    output logic      [31:0] burst_access_port
);

    timer_ccr_pkg::reg_access_t eff;
    timer_ccr_pkg::burst_cfg_t  cfg_q;
    timer_ccr_pkg::burst_cfg_t  cfg_d;

    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [3:0]  match_q;
    logic [3:0]  chan_match;
    logic [31:0] window_q;
    logic [31:0] window_d;
    logic [7:0]  dir_q;
    logic [7:0]  dir_d;
    logic [31:0] chan_word [4];
    logic [3:0]  hit_chan;
    logic        hit_window;
    logic        hit_ctrl;
    logic        hit_dir;
    logic        window_step;
    logic        ctrl_write;
    logic [7:0]  burst_target;
    logic [31:0] ctrl_word;
    logic [31:0] rd_word;

    // ==========================================================
    // Access routing
    // A window access is redirected to the burst target; the window
    // itself is excluded from the effective decode so a burst whose
    // target lands on it cannot loop back.
    assign hit_window  = (reg_addr == timer_ccr_pkg::DMA_WINDOW_OFF);
    assign window_step = hit_window && (reg_wr || reg_rd);
    assign eff.wr      = reg_wr;
    assign eff.rd      = reg_rd;
    assign eff.addr    = hit_window ? burst_target : reg_addr;
    assign eff.data    = reg_wdata;

    // ==========================================================
    // Effective address decode
    assign hit_ctrl   = (eff.addr == timer_ccr_pkg::DMA_CTRL_OFF);
    assign hit_dir    = (eff.addr == timer_ccr_pkg::CHAN_DIR_OFF);
    assign ctrl_write = eff.wr && hit_ctrl;

    // ==========================================================
    // Channel slots, one per channel
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_chan
            localparam logic [7:0] OFF = timer_ccr_pkg::CHAN1_VALUE_OFF
                + 8'(i) * timer_ccr_pkg::CHAN_STRIDE;
            assign hit_chan[i] = (eff.addr == OFF);
            chan_slot #(
                .WIDE       (WIDE)
            ) u_slot (
                .clock      (clock),
                .rst        (rst),
                .wr_en      (eff.wr && hit_chan[i]),
                .wr_data    (eff.data),
                .dir        (timer_ccr_pkg::dir_t'(dir_q[2*i +: 2])),
                .cap_event  (capture_event[i]),
                .cap_level  (capture_level[i]),
                .count      (counter),
                .value_word (chan_word[i]),
                .match      (chan_match[i])
            );
        end
    endgenerate

    // ==========================================================
    // Burst walker
    burst_walk u_walk (
        .clock     (clock),
        .rst       (rst),
        .cfg       (cfg_q),
        .cfg_write (ctrl_write),
        .step      (window_step),
        .index_q   (burst_index),
        .target    (burst_target)
    );

    // ==========================================================
    // Control and direction registers
    assign cfg_d.len  = ctrl_write ? eff.data[timer_ccr_pkg::LEN_MSB:
                                              timer_ccr_pkg::LEN_LSB]
                                   : cfg_q.len;
    assign cfg_d.base = ctrl_write ? eff.data[timer_ccr_pkg::BASE_MSB:
                                              timer_ccr_pkg::BASE_LSB]
                                   : cfg_q.base;
    assign dir_d      = (eff.wr && hit_dir) ? eff.data[7:0] : dir_q;
    // Window keeps the last word that went through it either way
    assign window_d   = !window_step ? window_q :
                        reg_wr       ? reg_wdata : rd_word;

    // Reserved control bits are simply never stored
    assign ctrl_word = {16'h0000, 3'h0, cfg_q.len, 3'h0, cfg_q.base};

    // ==========================================================
    // Read mux; unmapped or self-targeted addresses read zero
    assign rd_word = hit_chan[0] ? chan_word[0] :
                     hit_chan[1] ? chan_word[1] :
                     hit_chan[2] ? chan_word[2] :
                     hit_chan[3] ? chan_word[3] :
                     hit_ctrl    ? ctrl_word :
                     hit_dir     ? {24'h000000, dir_q} :
                                   32'h0000_0000;
    // Data stands only in the cycle after the strobe
    assign rdata_d = eff.rd ? rd_word : 32'h0000_0000;

    // ==========================================================
    // Registers of this level
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_q    <= {timer_ccr_pkg::FIELD_RST, timer_ccr_pkg::FIELD_RST};
            dir_q    <= timer_ccr_pkg::DIR_RST;
            window_q <= timer_ccr_pkg::WINDOW_RST;
            rdata_q  <= 32'h0000_0000;
            match_q  <= 4'h0;
        end else begin
            cfg_q    <= cfg_d;
            dir_q    <= dir_d;
            window_q <= window_d;
            rdata_q  <= rdata_d;
            match_q  <= chan_match;
        end
    end

    // Outputs, each from a flop
    assign reg_rdata         = rdata_q;
    assign compare_match     = match_q;
    assign burst_access_port = window_q;

    // ==========================================================
    // Checks
    chk_chan_low_write: assert property (
        @(posedge clock) disable iff (rst)
        (reg_wr && reg_addr == timer_ccr_pkg::CHAN1_VALUE_OFF
         && dir_q[1:0] == 2'b00)
        |=> (chan_word[0][15:0] == $past(reg_wdata[15:0])))
        else $error("channel one low half not written");

    chk_upper_bits_zero: assert property (
        @(posedge clock) disable iff (rst)
        WIDE || (chan_word[1][31:17] == 15'h0000))
        else $error("narrow channel upper bits not zero");

    chk_level_capture: assert property (
        @(posedge clock) disable iff (rst)
        (capture_event[0] && dir_q[1:0] != 2'b00)
        |=> (WIDE ? chan_word[0] == $past(counter)
                  : chan_word[0][16] == $past(capture_level[0])))
        else $error("level flag not latched on capture");

    chk_wide_value: assert property (
        @(posedge clock) disable iff (rst)
        (WIDE && reg_wr && reg_addr == timer_ccr_pkg::CHAN3_VALUE_OFF
         && dir_q[5:4] == 2'b00)
        |=> (chan_word[2] == $past(reg_wdata)))
        else $error("wide channel three not fully written");

    chk_chan4_decode: assert property (
        @(posedge clock) disable iff (rst)
        (reg_rd && reg_addr == timer_ccr_pkg::CHAN4_VALUE_OFF)
        |=> (reg_rdata == $past(chan_word[3])))
        else $error("channel four read mismatch");

    chk_burst_target: assert property (
        @(posedge clock) disable iff (rst)
        (reg_rd && hit_window
         && burst_target == timer_ccr_pkg::CHAN2_VALUE_OFF)
        |=> (reg_rdata == $past(chan_word[1])))
        else $error("window read not routed to burst target");

    chk_window_write: assert property (
        @(posedge clock) disable iff (rst)
        (reg_wr && hit_window)
        |=> (burst_access_port == $past(reg_wdata)))
        else $error("window word not kept");

    chk_ctrl_reserved: assert property (
        @(posedge clock) disable iff (rst)
        (reg_rd && reg_addr == timer_ccr_pkg::DMA_CTRL_OFF)
        |=> (reg_rdata[31:13] == 19'h00000 && reg_rdata[7:5] == 3'h0))
        else $error("control reserved bits not zero");

    chk_capture_no_match: assert property (
        @(posedge clock) disable iff (rst)
        (dir_q[1:0] != 2'b00) |=> !compare_match[0])
        else $error("capture channel reported a compare match");

    chk_compare_match: assert property (
        @(posedge clock) disable iff (rst)
        (dir_q[1:0] == 2'b00 && chan_match[0]) |=> compare_match[0])
        else $error("compare match not flagged");

    chk_chan2_low_write: assert property (
        @(posedge clock) disable iff (rst)
        (reg_wr && reg_addr == timer_ccr_pkg::CHAN2_VALUE_OFF
         && dir_q[3:2] == 2'b00)
        |=> (chan_word[1][15:0] == $past(reg_wdata[15:0])))
        else $error("channel two low half not written");

    chk_narrow_high_zero: assert property (
        @(posedge clock) disable iff (rst)
        WIDE || (chan_word[0][31:17] == 15'h0000
                 && chan_word[2][31:17] == 15'h0000
                 && chan_word[3][31:17] == 15'h0000))
        else $error("narrow channel reserved bits not zero");

    // Level flag moves only with a capture, never with a write
    chk_level_hold: assert property (
        @(posedge clock) disable iff (rst)
        (!WIDE && !capture_event[0]) |=> $stable(chan_word[0][16]))
        else $error("level flag changed without a capture");

    chk_wide_chan1: assert property (
        @(posedge clock) disable iff (rst)
        (WIDE && reg_wr && reg_addr == timer_ccr_pkg::CHAN1_VALUE_OFF
         && dir_q[1:0] == 2'b00)
        |=> (chan_word[0] == $past(reg_wdata)))
        else $error("wide channel one not fully written");

    chk_chan1_decode: assert property (
        @(posedge clock) disable iff (rst)
        (reg_rd && reg_addr == timer_ccr_pkg::CHAN1_VALUE_OFF)
        |=> (reg_rdata == $past(chan_word[0])))
        else $error("channel one read mismatch");

    chk_chan2_decode: assert property (
        @(posedge clock) disable iff (rst)
        (reg_rd && reg_addr == timer_ccr_pkg::CHAN2_VALUE_OFF)
        |=> (reg_rdata == $past(chan_word[1])))
        else $error("channel two read mismatch");

    // Index stays inside the programmed length at all times
    chk_index_max: assert property (
        @(posedge clock) disable iff (rst)
        burst_index <= cfg_q.len)
        else $error("burst index beyond programmed length");

    chk_index_step: assert property (
        @(posedge clock) disable iff (rst)
        (window_step && !ctrl_write && burst_index != cfg_q.len)
        |=> (burst_index == $past(burst_index) + 5'h01))
        else $error("burst index did not advance");

    chk_ctrl_resets_index: assert property (
        @(posedge clock) disable iff (rst)
        ctrl_write |=> (burst_index == 5'h00))
        else $error("control write did not restart the burst");

    chk_window_write_chan: assert property (
        @(posedge clock) disable iff (rst)
        (reg_wr && hit_window && dir_q[1:0] == 2'b00
         && burst_target == timer_ccr_pkg::CHAN1_VALUE_OFF)
        |=> (chan_word[0][15:0] == $past(reg_wdata[15:0])))
        else $error("window write missed channel one");

    chk_window_read_port: assert property (
        @(posedge clock) disable iff (rst)
        (reg_rd && hit_window) |=> (burst_access_port == reg_rdata))
        else $error("window read word not kept");

    chk_port_hold: assert property (
        @(posedge clock) disable iff (rst)
        !window_step |=> $stable(burst_access_port))
        else $error("window word changed without an access");

    // A compare channel changes only by software
    chk_capture_hold: assert property (
        @(posedge clock) disable iff (rst)
        (dir_q[1:0] == 2'b00 && !(eff.wr && hit_chan[0]))
        |=> $stable(chan_word[0]))
        else $error("compare channel value changed by itself");

    chk_capture_value: assert property (
        @(posedge clock) disable iff (rst)
        (capture_event[0] && dir_q[1:0] != 2'b00)
        |=> (chan_word[0][15:0] == $past(counter[15:0])))
        else $error("capture did not copy the counter");

    chk_match_equal: assert property (
        @(posedge clock) disable iff (rst)
        (dir_q[3:2] == 2'b00
         && (WIDE ? chan_word[1] == counter
                  : chan_word[1][15:0] == counter[15:0]))
        |=> compare_match[1])
        else $error("equal compare value not flagged");

endmodule // timer_ccr_regs

// file: rtl/timer_ccr_pkg.sv
// Shared constants and types for the timer value and burst register block
package timer_ccr_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] CTRL1_OFF       = 8'h00;
    localparam logic [7:0] CHAN1_VALUE_OFF = 8'h34;
    localparam logic [7:0] CHAN2_VALUE_OFF = 8'h38;
    localparam logic [7:0] CHAN3_VALUE_OFF = 8'h3c;
    localparam logic [7:0] CHAN4_VALUE_OFF = 8'h40;
    localparam logic [7:0] CHAN_STRIDE     = 8'h04;
    localparam logic [7:0] DMA_CTRL_OFF    = 8'h48;
    localparam logic [7:0] DMA_WINDOW_OFF  = 8'h4c;
    localparam logic [7:0] CHAN_DIR_OFF    = 8'h60;

    // ==========================================================
    // Field positions
    localparam int LEVEL_BIT = 16;
    localparam int LEN_LSB   = 8;
    localparam int LEN_MSB   = 12;
    localparam int BASE_LSB  = 0;
    localparam int BASE_MSB  = 4;

    // ==========================================================
    // Reset values
    localparam logic [31:0] VALUE_RST  = 32'h0000_0000;
    localparam logic [31:0] WINDOW_RST = 32'h0000_0000;
    localparam logic [4:0]  FIELD_RST  = 5'h00;
    localparam logic [7:0]  DIR_RST    = 8'h00;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        DIR_COMPARE = 2'b00,
        DIR_CAP_OWN = 2'b01,
        DIR_CAP_NBR = 2'b10,
        DIR_CAP_TRG = 2'b11
    } dir_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] data;
    } reg_access_t;

    typedef struct packed {
        logic [4:0] len;
        logic [4:0] base;
    } burst_cfg_t;

endpackage

// file: rtl/chan_slot.sv
// One compare/capture channel value register, with its level flag in narrow instances
`timescale 1ns/1ps
module chan_slot #(
    parameter bit WIDE = 1'b0
) (
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                rst,
    // Software write
    input  wire logic                wr_en,
    input  wire logic [31:0]         wr_data,
    // Timer side
    input  wire timer_ccr_pkg::dir_t dir,
    input  wire logic                cap_event,
    input  wire logic                cap_level,
    input  wire logic [31:0]         count,
    // Results
    output logic      [31:0]         value_word,
    output logic                     match
);

    logic [31:0] value_q;
    logic [31:0] value_d;
    logic        level_q;
    logic        level_d;
    logic [31:0] count_view;
    logic        capture;

    // ==========================================================
    // Next value: capture wins over a write in the same cycle
    assign count_view = WIDE ? count : {16'h0000, count[15:0]};
    assign capture    = (dir != timer_ccr_pkg::DIR_COMPARE) && cap_event;
    assign value_d    = capture ? count_view :
                        wr_en   ? (WIDE ? wr_data
                                        : {16'h0000, wr_data[15:0]})
                                : value_q;
    assign level_d    = capture ? (WIDE ? 1'b0 : cap_level)
                                : level_q;

    // Storage
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            value_q <= timer_ccr_pkg::VALUE_RST;
            level_q <= 1'b0;
        end else begin
            value_q <= value_d;
            level_q <= level_d;
        end
    end

    // Read view; narrow instances show the level flag, upper bits zero
    assign value_word = WIDE ? value_q
                             : {15'h0000, level_q, value_q[15:0]};
    assign match      = (dir == timer_ccr_pkg::DIR_COMPARE)
                        && (value_q == count_view);

endmodule // chan_slot

// file: rtl/burst_walk.sv
// Burst index walker that steers window accesses onto the register set
`timescale 1ns/1ps
module burst_walk (
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      rst,
    // Configuration
    input  wire timer_ccr_pkg::burst_cfg_t cfg,
    input  wire logic                      cfg_write,
    // One window access per pulse
    input  wire logic                      step,
    // Position
    output logic      [4:0]                index_q,
    output logic      [7:0]                target
);

    logic [4:0] index_d;
    logic [5:0] slot;
    logic       last;

    // ==========================================================
    // Length field plus one transfers, then back to the base
    assign last    = (index_q == cfg.len);
    assign index_d = cfg_write ? 5'h00 :
                     step      ? (last ? 5'h00 : index_q + 5'h01) :
                                 index_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            index_q <= timer_ccr_pkg::FIELD_RST;
        end else begin
            index_q <= index_d;
        end
    end

    // Word slot counted from the first control register
    assign slot   = {1'b0, cfg.base} + {1'b0, index_q};
    assign target = timer_ccr_pkg::CTRL1_OFF + {slot, 2'b00};

    // Index never runs past the programmed length
    chk_index_bound: assert property (
        @(posedge clock) disable iff (rst)
        (step && !cfg_write && last) |=> (index_q == 5'h00))
        else $error("burst index did not wrap after last transfer");

endmodule // burst_walk

// file: test/bus_master.sv
// Bus master model driving the timer register port
`timescale 1ns/1ps
module bus_master (
    // Clock
    input  wire logic        clock,
    // Register port
    output logic      [7:0]  reg_addr,
    output logic      [31:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [31:0] reg_rdata
);
    // Idle bus from time zero
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // One-cycle write strobe beside address and data
    task automatic write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    // Data is taken mid-cycle, while it stands; sampling at the closing
    // edge would race the flop that clears it
    task automatic read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        @(negedge clock);
        d = reg_rdata;
    endtask
endmodule // bus_master

// file: test/tb_top.sv
// Self-checking testbench for the timer value and burst registers
`timescale 1ns/1ps
module tb_top;
    // ==========================================================
    // Clock, reset and design hookup
    logic        clock         = 1'b0;
    logic        rst           = 1'b1;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [31:0] counter       = 32'h0000_0000;
    logic [3:0]  capture_event = 4'h0;
    logic [3:0]  capture_level = 4'h0;
    logic [3:0]  compare_match;
    logic [4:0]  burst_index;
    logic [31:0] burst_access_port;
    logic [31:0] rd_word;
    logic [31:0] wide_rdata;
    int          miscompares   = 0;
    int          checked       = 0;

    // 50 MHz clock
    always #10 clock = ~clock;

    bus_master i_bus_master (
        .clock     (clock),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (reg_rdata)
    );

    // Narrow instance, the one with level flags
    timer_ccr_regs #(.WIDE(1'b0)) i_timer_ccr_regs (
        .clock             (clock),
        .rst               (rst),
        .reg_addr          (reg_addr),
        .reg_wdata         (reg_wdata),
        .reg_wr            (reg_wr),
        .reg_rd            (reg_rd),
        .reg_rdata         (reg_rdata),
        .counter           (counter),
        .capture_event     (capture_event),
        .capture_level     (capture_level),
        .compare_match     (compare_match),
        .burst_index       (burst_index),
        .burst_access_port (burst_access_port)
    );

    // Wide instance on the same bus; only its read data is judged
    if (1) begin : g_wide
        timer_ccr_regs #(.WIDE(1'b1)) i_timer_ccr_regs (
            .clock             (clock),
            .rst               (rst),
            .reg_addr          (reg_addr),
            .reg_wdata         (reg_wdata),
            .reg_wr            (reg_wr),
            .reg_rd            (reg_rd),
            .reg_rdata         (wide_rdata),
            .counter           (counter),
            .capture_event     (capture_event),
            .capture_level     (capture_level),
            .compare_match     (),
            .burst_index       (),
            .burst_access_port ()
        );
    end

    // ==========================================================
    // Comparison and verdict
    task automatic check_word(input logic [31:0] got,
                              input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic read_check(input logic [7:0] a, input logic [31:0] exp);
        i_bus_master.read(a, rd_word);
        check_word(rd_word, exp);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    // Channels one and four, the control register and the window read zero straight out of reset
    task automatic reset_values;
        read_check(8'h34, 32'h0000_0000);
        read_check(8'h40, 32'h0000_0000);
        read_check(8'h48, 32'h0000_0000);
        read_check(timer_ccr_pkg::DMA_WINDOW_OFF, 32'h0000_0000);
    endtask

    // All ones into every channel and the control register shows which bits really exist
    task automatic field_widths;
        for (int i = 0; i < 4; i++) begin
            i_bus_master.write(8'h34 + 8'(4 * i), 32'hffff_ffff);
            read_check(8'h34 + 8'(4 * i), 32'h0000_ffff);
            check_word(wide_rdata, 32'hffff_ffff);
        end
        i_bus_master.write(8'h48, 32'hffff_ffff);
        read_check(8'h48, 32'h0000_1f1f);
        i_bus_master.write(8'h44, 32'h1234_5678);
        read_check(8'h44, 32'h0000_0000);
    endtask

    // Two-step burst from channel one, then a single-step burst
    task automatic burst_walk_run;
        i_bus_master.write(timer_ccr_pkg::CHAN_DIR_OFF, 32'h0000_0000);
        i_bus_master.write(8'h48, 32'h0000_010d);
        @(negedge clock);
        check_word({27'h0, burst_index}, 32'h0000_0000);
        i_bus_master.write(8'h4c, 32'h1111_2222);
        @(negedge clock);
        check_word({27'h0, burst_index}, 32'h0000_0001);
        check_word(burst_access_port, 32'h1111_2222);
        i_bus_master.write(8'h4c, 32'h3333_4444);
        @(negedge clock);
        check_word({27'h0, burst_index}, 32'h0000_0000);
        read_check(8'h34, 32'h0000_2222);
        read_check(8'h38, 32'h0000_4444);
        i_bus_master.write(8'h48, 32'h0000_000e);
        i_bus_master.write(8'h4c, 32'h0000_5555);
        @(negedge clock);
        check_word({27'h0, burst_index}, 32'h0000_0000);
        read_check(8'h38, 32'h0000_5555);
        read_check(timer_ccr_pkg::DMA_WINDOW_OFF, 32'h0000_5555);
        check_word(burst_access_port, 32'h0000_5555);
    endtask

    // Channel one captures, channel two compares
    task automatic capture_compare;
        i_bus_master.write(timer_ccr_pkg::CHAN_DIR_OFF, 32'h0000_0001);
        @(posedge clock);
        counter       <= 32'h0000_abcd;
        capture_level <= 4'h1;
        capture_event <= 4'h1;
        @(posedge clock);
        capture_event <= 4'h0;
        read_check(8'h34, 32'h0001_abcd);
        check_word(wide_rdata, 32'h0000_abcd);
        @(posedge clock);
        counter <= 32'h0000_5555;
        repeat (2) @(posedge clock);
        @(negedge clock);
        check_word({31'h0, compare_match[1]}, 32'h0000_0001);
        // Equal value on a capture channel must not match
        @(posedge clock);
        counter <= 32'h0000_abcd;
        repeat (2) @(posedge clock);
        @(negedge clock);
        check_word({31'h0, compare_match[0]}, 32'h0000_0000);
    endtask

    // Reset in mid-run brings written registers back to zero
    task automatic reset_midrun;
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        read_check(8'h34, 32'h0000_0000);
        check_word(wide_rdata, 32'h0000_0000);
        read_check(8'h48, 32'h0000_0000);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        reset_values;
        field_widths;
        burst_walk_run;
        capture_compare;
        reset_midrun;
        report_and_stop;
    end

    // Whole run needs under a hundred cycles; cut a hang well beyond it
    initial begin
        repeat (3000) @(posedge clock);
        miscompares++;
        report_and_stop;
    end
endmodule // tb_top
